/* File: vmcsr_consts.vh */
/*
 Constants for the control and status register bank: offsets, field positions,
 reset values and widths. Assumes inclusion by the register bank modules only.
*/
// Behaviour
// - Every reset loads slot position from backplane lines
// - Slot position is five bits, address bits 23..19
// - Without slot connector: writable, defaults all ones
// - With slot connector: slot writes get no acknowledge
// - Written slot value applies only after next soft reset; hard reset restores all ones
// - Chain address holds upper bits, resets to 0xAA
// - Bit-set register sets ones, reads current contents
// - Bit-clear register clears ones in control register
// - Bus error flag set by transfer error or software
// - Hard reset clears all; soft reset clears bit3
// - Base-select chooses rotary switch or relocation registers
// - Soft reset bit holds reset until cleared
// - Interrupt level three bits, zero disables interrupts
// - Vector byte driven during interrupt acknowledge, default zero
// - Event available when a complete event buffered
// - Chain event available is OR of ready lines
// - Busy covers conversion, reset, buffer full, memory test
// - Chain busy is OR of busy lines
// - Slot id missing when no backplane slot number
// - Purged when chained transfer data all sent
// - Termination on/off only when all agree
// - Threshold flag: trigger >= count, level and trigger nonzero
// - Slot position feeds output word bits 31..27
// - Interrupt when stored count equals nonzero trigger
`ifndef VMCSR_CONSTS_VH
`define VMCSR_CONSTS_VH
`define VMCSR_OFS_SLOT        16'h1002
`define VMCSR_OFS_CHAIN       16'h1004
`define VMCSR_OFS_BSET        16'h1006
`define VMCSR_OFS_BCLR        16'h1008
`define VMCSR_OFS_ILEVEL      16'h100A
`define VMCSR_OFS_IVECTOR     16'h100C
`define VMCSR_OFS_STATUS      16'h100E
`define VMCSR_RST_SLOT        5'h1F
`define VMCSR_RST_CHAIN       8'hAA
`define VMCSR_RST_ILEVEL      3'h0
`define VMCSR_RST_IVECTOR     8'h00
`define VMCSR_BIT_BERR        3
`define VMCSR_BIT_SELADDR     4
`define VMCSR_BIT_SOFTRST     7
`define VMCSR_BSET_MASK       8'h98
`define VMCSR_ST_EVAIL        0
`define VMCSR_ST_BUSY         2
`define VMCSR_ST_CHAIN_EVAIL  1
`define VMCSR_ST_CHAIN_BUSY   3
`define VMCSR_ST_SLOT_MISS    4
`define VMCSR_ST_PURGED       5
`define VMCSR_ST_TERM_ON      6
`define VMCSR_ST_TERM_OFF     7
`define VMCSR_ST_THRESH       8
`define VMCSR_N_TERM          4
`endif

/* File: vmcsr_sync.v */
/*
 Two-flop synchroniser for a bus of pin levels.
 Assumes the inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/100ps
module vmcsr_sync #(
  parameter W = 1
) (
  input  wire         i_sys_clk, // System clock
  input  wire         i_ce,      // Clock enable
  input  wire [W-1:0] i_async,   // Asynchronous levels
  output reg  [W-1:0] o_sync     // Synchronised levels
);
  reg [W-1:0] meta_q;

  always @(posedge i_sys_clk) begin
    if (i_ce) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

/* File: vmcsr_thresh.v */
/*
 Event threshold comparison: interrupt request and threshold flag.
 Assumes count and trigger come from same-clock logic.
*/
`timescale 1ns/100ps
`include "vmcsr_consts.vh"
module vmcsr_thresh (
  input  wire       i_sys_clk,   // System clock
  input  wire       i_ce,        // Clock enable
  input  wire       i_rst,       // Active-high hardware reset
  input  wire [4:0] i_trigger,   // Event trigger value
  input  wire [4:0] i_count,     // Stored event count
  input  wire [2:0] i_level,     // Interrupt level
  output reg        o_irq_req,   // Interrupt request level
  output reg        o_thresh     // Threshold reached flag
);
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_irq_req <= 1'b0;
      o_thresh  <= 1'b0;
    end else if (i_ce) begin
      o_irq_req <= (i_trigger != 5'h00) && (i_count == i_trigger) && (i_level != 3'h0);
      o_thresh  <= (i_trigger >= i_count) && (i_level != 3'h0) && (i_trigger != 5'h00);
    end
  end
endmodule

/* File: vmcsr_regs.v */
/*
 Control and status register bank of the digitizer module. Register reads,
 writes, acknowledge, interrupt vector and status assembly.
 Assumes a decoded VME slave cycle (address, strobes) in the system clock
 domain; backplane and control-bus pins are asynchronous and synchronised here.
*/
`timescale 1ns/100ps
`include "vmcsr_consts.vh"
module vmcsr_regs #(
  parameter HAS_SLOT_AUX = 1'b1
) (
  input  wire        i_sys_clk,          // System clock, 100 MHz
  input  wire        i_nrst,             // Sync hardware reset, active low
  input  wire        i_ce,               // Clock enable
  input  wire        i_wr_stb,           // Register write strobe, one cycle
  input  wire        i_rd_stb,           // Register read strobe, one cycle
  input  wire [15:0] i_addr,             // Register byte offset
  input  wire [15:0] i_wdata,            // Write data
  input  wire        i_iack,             // Interrupt acknowledge strobe
  input  wire [4:0]  i_slot_number_lines,// Backplane slot lines (async)
  input  wire        i_slot_lines_valid, // Backplane slot present (async)
  input  wire        i_front_soft_reset, // Extra soft reset request, pulse
  input  wire        i_bus_error_event,  // Bus error issued, pulse
  input  wire        i_event_available,  // Complete event buffered
  input  wire        i_conv_busy,        // Conversion in progress
  input  wire        i_buf_full,         // Output buffer full
  input  wire        i_mem_test,         // Memory test mode active
  input  wire        i_purged,           // Chained transfer finished
  input  wire [4:0]  i_event_count,      // Stored event count
  input  wire [4:0]  i_event_trigger,    // Event trigger value
  input  wire        i_chain_ready,      // Control bus ready OR (async)
  input  wire        i_chain_busy,       // Control bus busy OR (async)
  input  wire [3:0]  i_term_sw,          // Termination switches (async)
  output reg  [15:0] o_rdata,            // Read / vector data
  output reg         o_ack,              // Data acknowledge, one cycle
  output reg  [4:0]  o_slot_position,    // Slot for output words
  output reg  [7:0]  o_chain_addr,       // Chained/multicast address bits
  output reg         o_base_sel,         // 1: relocation regs, 0: rotary
  output reg         o_module_reset,     // Module reset, active high
  output reg  [2:0]  o_irq_level,        // Active interrupt level
  output reg         o_irq_req           // Interrupt request
);
  wire        rst;
  wire [4:0]  slot_lines_s;
  wire        slot_valid_s;
  wire        chain_ready_s;
  wire        chain_busy_s;
  wire [3:0]  term_s;
  wire        irq_req_w;
  wire        thresh_w;
  reg  [4:0]  slot_wr_q;
  reg  [7:0]  bset_q;
  reg  [7:0]  bset_d;
  reg  [7:0]  ivec_q;
  reg         slot_miss_q;
  reg         hard_done_q;
  reg         soft_pend_q;
  reg  [15:0] status_d;
  reg  [15:0] rd_d;
  reg         hit_d;

  assign rst = ~i_nrst;

  vmcsr_sync #(.W(12)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_ce      (i_ce),
    .i_async   ({i_slot_number_lines, i_slot_lines_valid, i_chain_ready,
                 i_chain_busy, i_term_sw}),
    .o_sync    ({slot_lines_s, slot_valid_s, chain_ready_s, chain_busy_s, term_s})
  );

  vmcsr_thresh u_thresh (
    .i_sys_clk (i_sys_clk),
    .i_ce      (i_ce),
    .i_rst     (rst),
    .i_trigger (i_event_trigger),
    .i_count   (i_event_count),
    .i_level   (o_irq_level),
    .o_irq_req (irq_req_w),
    .o_thresh  (thresh_w)
  );

  wire wr_slot  = i_wr_stb && (i_addr == `VMCSR_OFS_SLOT);
  wire wr_chain = i_wr_stb && (i_addr == `VMCSR_OFS_CHAIN);
  wire wr_bset  = i_wr_stb && (i_addr == `VMCSR_OFS_BSET);
  wire wr_bclr  = i_wr_stb && (i_addr == `VMCSR_OFS_BCLR);
  wire wr_ilev  = i_wr_stb && (i_addr == `VMCSR_OFS_ILEVEL);
  wire wr_ivec  = i_wr_stb && (i_addr == `VMCSR_OFS_IVECTOR);
  // Soft reset: held bit or an external single pulse
  wire soft_rst = bset_q[`VMCSR_BIT_SOFTRST] || i_front_soft_reset;

  // Bit set/clear; hardware events win over a clear in the same cycle
  always @* begin
    bset_d = bset_q;
    if (wr_bset)
      bset_d = bset_d | (i_wdata[7:0] & `VMCSR_BSET_MASK);
    if (wr_bclr)
      bset_d = bset_d & ~(i_wdata[7:0] & `VMCSR_BSET_MASK);
    if (soft_pend_q)
      bset_d[`VMCSR_BIT_BERR] = 1'b0;
    if (i_bus_error_event)
      bset_d[`VMCSR_BIT_BERR] = 1'b1;
  end

  always @(posedge i_sys_clk) begin
    if (rst) begin
      bset_q <= 8'h00;
    end else if (i_ce) begin
      bset_q <= bset_d;
    end
  end

  // Slot write latch; applied to the slot position only by a soft reset, hard reset reloads 0x1F
  always @(posedge i_sys_clk) begin
    if (rst) begin
      slot_wr_q   <= `VMCSR_RST_SLOT;
      hard_done_q <= 1'b0;
      soft_pend_q <= 1'b0;
    end else if (i_ce) begin
      hard_done_q <= 1'b1;
      soft_pend_q <= soft_rst;
      if (wr_slot && !HAS_SLOT_AUX)
        slot_wr_q <= i_wdata[4:0];
    end
  end

  // Slot load follows every reset, hard and soft, after the sync settles
  always @(posedge i_sys_clk) begin
    if (rst) begin
      o_slot_position <= `VMCSR_RST_SLOT;
      slot_miss_q     <= 1'b1;
    end else if (i_ce && (!hard_done_q || soft_pend_q)) begin
      if (HAS_SLOT_AUX && slot_valid_s) begin
        o_slot_position <= slot_lines_s;
        slot_miss_q     <= 1'b0;
      end else begin
        o_slot_position <= slot_wr_q;
        slot_miss_q     <= 1'b1;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (rst) begin
      o_chain_addr <= `VMCSR_RST_CHAIN;
      o_irq_level  <= `VMCSR_RST_ILEVEL;
      ivec_q       <= `VMCSR_RST_IVECTOR;
    end else if (i_ce) begin
      if (wr_chain)
        o_chain_addr <= i_wdata[7:0];
      if (wr_ilev)
        o_irq_level <= i_wdata[2:0];
      if (wr_ivec)
        ivec_q <= i_wdata[7:0];
    end
  end

  always @* begin
    status_d = 16'h0000;
    status_d[`VMCSR_ST_EVAIL]       = i_event_available;
    status_d[`VMCSR_ST_CHAIN_EVAIL] = chain_ready_s;
    status_d[`VMCSR_ST_BUSY]        = i_conv_busy || i_buf_full || i_mem_test
                                      || o_module_reset;
    status_d[`VMCSR_ST_CHAIN_BUSY]  = chain_busy_s;
    status_d[`VMCSR_ST_SLOT_MISS]   = slot_miss_q;
    status_d[`VMCSR_ST_PURGED]      = i_purged;
    status_d[`VMCSR_ST_TERM_ON]     = &term_s;
    status_d[`VMCSR_ST_TERM_OFF]    = ~|term_s;
    status_d[`VMCSR_ST_THRESH]      = thresh_w;
  end

  // Read mux and acknowledge; unmapped offsets and aux slot writes go unanswered
  always @* begin
    rd_d  = 16'h0000;
    hit_d = 1'b0;
    if (i_iack) begin
      rd_d  = {8'h00, ivec_q};
      hit_d = 1'b1;
    end else if (i_rd_stb || i_wr_stb) begin
      hit_d = 1'b1;
      case (i_addr)
        `VMCSR_OFS_SLOT: begin
          rd_d  = {11'h000, o_slot_position};
          hit_d = !(i_wr_stb && HAS_SLOT_AUX);
        end
        `VMCSR_OFS_CHAIN:   rd_d = {8'h00, o_chain_addr};
        `VMCSR_OFS_BSET:    rd_d = {8'h00, bset_q};
        `VMCSR_OFS_BCLR:    rd_d = {8'h00, bset_q};
        `VMCSR_OFS_ILEVEL:  rd_d = {13'h0000, o_irq_level};
        `VMCSR_OFS_IVECTOR: rd_d = {8'h00, ivec_q};
        `VMCSR_OFS_STATUS:  rd_d = status_d;
        default:            hit_d = 1'b0;
      endcase
    end
  end

  always @(posedge i_sys_clk) begin
    if (rst) begin
      o_rdata        <= 16'h0000;
      o_ack          <= 1'b0;
      o_base_sel     <= 1'b0;
      o_module_reset <= 1'b1;
      o_irq_req      <= 1'b0;
    end else if (i_ce) begin
      o_rdata        <= (i_rd_stb || i_iack) ? rd_d : 16'h0000;
      o_ack          <= hit_d;
      o_base_sel     <= bset_q[`VMCSR_BIT_SELADDR];
      o_module_reset <= soft_rst;
      o_irq_req      <= irq_req_w;
    end
  end
endmodule

/* File: vmcsr_asserts.sv */
/* Port checker for the control and status register bank.
   Assumes bind onto vmcsr_regs, one clock, synchronous active-low reset. */
`timescale 1ns/100ps
module vmcsr_asserts #(parameter HAS_SLOT_AUX = 1'b1) (
  input wire        i_sys_clk, i_nrst, i_ce, i_wr_stb, i_rd_stb, i_iack, // Clock, bus
  input wire [15:0] i_addr, i_wdata, o_rdata,                           // Address, data
  input wire        o_ack, o_base_sel, o_module_reset, o_irq_req,       // Outputs
  input wire [7:0]  o_chain_addr,                                       // Chain bits
  input wire [2:0]  o_irq_level                                         // Level
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  wire wr = i_wr_stb && i_ce;
  wire rd = i_rd_stb && i_ce;
  slot_wr_a: assert property (HAS_SLOT_AUX && wr && i_addr == 16'h1002 |=> !o_ack)
    else $error("slot write acknowledged");
  ivec_a: assert property (i_iack && i_ce |=> o_ack && o_rdata[15:8] == 8'h00)
    else $error("vector cycle wrong");
  level_rd_a: assert property (rd && i_addr == 16'h100A |=> o_ack && o_rdata[15:3] == 13'h0)
    else $error("level read wrong");
  chain_rst_a: assert property ($rose(i_nrst) |-> o_chain_addr == 8'hAA)
    else $error("chain address reset value wrong");
  bit_set_a: assert property (wr && i_addr == 16'h1006 && i_wdata[4] |-> ##[1:2] o_base_sel)
    else $error("base select not set");
  bit_clr_a: assert property (wr && i_addr == 16'h1008 && i_wdata[4] |-> ##[1:2] !o_base_sel)
    else $error("base select not cleared");
  soft_rst_a: assert property (wr && i_addr == 16'h1006 && i_wdata[7] |-> ##[1:3] o_module_reset)
    else $error("held reset not entered");
  idle_data_a: assert property (!o_ack |-> o_rdata == 16'h0000)
    else $error("read data outside acknowledge");
  irq_off_a: assert property (o_irq_level == 3'h0 && $past(o_irq_level) == 3'h0 &&
    $past(o_irq_level, 2) == 3'h0 |-> !o_irq_req) else $error("request at level zero");
  cover property (o_module_reset ##1 !o_module_reset);
  cover property (o_irq_req);
  cover property (i_iack ##1 o_ack);
endmodule
bind vmcsr_regs vmcsr_asserts #(.HAS_SLOT_AUX(HAS_SLOT_AUX)) u_vmcsr_asserts (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_wr_stb(i_wr_stb),
  .i_rd_stb(i_rd_stb), .i_iack(i_iack), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_ack(o_ack), .o_base_sel(o_base_sel), .o_module_reset(o_module_reset),
  .o_irq_req(o_irq_req), .o_chain_addr(o_chain_addr), .o_irq_level(o_irq_level));

/* File: vmcsr_master.sv */
/* Bus master model issuing one-cycle register and acknowledge strobes.
   Assumes the bank answers one cycle after the strobe edge. */
`timescale 1ns/100ps
module vmcsr_master (
  input  wire        i_sys_clk, // System clock
  input  wire        i_ack,     // Acknowledge
  input  wire [15:0] i_rdata,   // Read data
  output logic       o_wr_stb,  // Write strobe
  output logic       o_rd_stb,  // Read strobe
  output logic       o_iack,    // Vector strobe
  output logic [15:0] o_addr,   // Offset
  output logic [15:0] o_wdata   // Write data
);
  initial {o_wr_stb, o_rd_stb, o_iack, o_addr, o_wdata} = '0;
  // Kind 0 read, 1 write, 2 vector; no ack within two edges is a timeout
  task automatic xfer(input logic [1:0] k, input logic [15:0] a, d,
                      output logic ok, output logic [15:0] q);
    ok = 1'b0;
    q = 16'h0000;
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= d;
    o_rd_stb <= (k == 2'd0);
    o_wr_stb <= (k == 2'd1);
    o_iack <= (k == 2'd2);
    @(posedge i_sys_clk);
    {o_wr_stb, o_rd_stb, o_iack} <= 3'b000;
    repeat (2) begin
      @(posedge i_sys_clk);
      if (i_ack === 1'b1 && !ok) begin
        ok = 1'b1;
        q = i_rdata;
      end
    end
  endtask
endmodule

/* File: testbench.sv */
/* Self-checking bench for the register bank.
   Assumes the master model for bus cycles and the bound port checker. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  logic i_sys_clk, i_nrst = 0, ev = 0, bsy = 0, full = 0, mt = 0, prg = 0, berr = 0;
  logic cr = 0, cb = 0, ok, ce = 1, vld = 1;
  logic [4:0] lines = 5'h0B, cnt = 5'h00, trg = 5'h00;
  logic [3:0] term = 4'h5;
  logic [15:0] q;
  wire wr, rd, iack, ack, base, mrst, irq;
  wire [15:0] addr, wdata, rdata;
  wire [4:0] slot, bare_slot;
  wire [7:0] chain;
  wire [2:0] lvl;
  int mismatches = 0, tests_run = 0;
  vmcsr_regs u_vmcsr_regs (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(ce),
    .i_wr_stb(wr), .i_rd_stb(rd), .i_addr(addr), .i_wdata(wdata), .i_iack(iack),
    .i_slot_number_lines(lines), .i_slot_lines_valid(vld), .i_front_soft_reset(1'b0),
    .i_bus_error_event(berr), .i_event_available(ev), .i_conv_busy(bsy), .i_buf_full(full),
    .i_mem_test(mt), .i_purged(prg), .i_event_count(cnt), .i_event_trigger(trg),
    .i_chain_ready(cr), .i_chain_busy(cb), .i_term_sw(term), .o_rdata(rdata), .o_ack(ack),
    .o_slot_position(slot), .o_chain_addr(chain), .o_base_sel(base),
    .o_module_reset(mrst), .o_irq_level(lvl), .o_irq_req(irq));
  vmcsr_master u_vmcsr_master (.i_sys_clk(i_sys_clk), .i_ack(ack), .i_rdata(rdata),
    .o_wr_stb(wr), .o_rd_stb(rd), .o_iack(iack), .o_addr(addr), .o_wdata(wdata));
  // Variant without slot lines: slot register writable, seen only by its slot output
  vmcsr_regs #(.HAS_SLOT_AUX(1'b0)) u_vmcsr_regs_bare (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_ce(ce), .i_wr_stb(wr), .i_rd_stb(rd), .i_addr(addr),
    .i_wdata(wdata), .i_iack(iack), .i_slot_number_lines(lines),
    .i_slot_lines_valid(1'b0), .i_front_soft_reset(1'b0), .i_bus_error_event(berr),
    .i_event_available(ev), .i_conv_busy(bsy), .i_buf_full(full), .i_mem_test(mt),
    .i_purged(prg), .i_event_count(cnt), .i_event_trigger(trg), .i_chain_ready(cr),
    .i_chain_busy(cb), .i_term_sw(term), .o_rdata(), .o_ack(),
    .o_slot_position(bare_slot), .o_chain_addr(), .o_base_sel(), .o_module_reset(),
    .o_irq_level(), .o_irq_req());
  task automatic rd_chk(input logic [15:0] a, e);
    u_vmcsr_master.xfer(2'd0, a, 16'h0000, ok, q);
    `CHK("ack", 1'b1, ok)
    `CHK("rdata", e, q)
  endtask
  task automatic wr_reg(input logic [15:0] a, d);
    u_vmcsr_master.xfer(2'd1, a, d, ok, q);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic hw_reset();
    i_nrst <= 1'b0;
    step(4);
    i_nrst <= 1'b1;
    step(2);
  endtask
  task automatic t_reset();
    rd_chk(16'h1004, 16'h00AA);
    rd_chk(16'h100A, 16'h0000);
    rd_chk(16'h100C, 16'h0000);
    rd_chk(16'h1006, 16'h0000);
    rd_chk(16'h100E, 16'h0000);
    `CHK("slot", 5'h0B, slot)
    `CHK("bare slot", 5'h1F, bare_slot)
  endtask
  task automatic t_bits();
    wr_reg(16'h1006, 16'h0018);
    rd_chk(16'h1006, 16'h0018);
    `CHK("base", 1'b1, base)
    wr_reg(16'h1006, 16'hFF67);
    rd_chk(16'h1006, 16'h0018);
    berr <= 1'b0;
    wr_reg(16'h1008, 16'h0008);
    rd_chk(16'h1006, 16'h0010);
    @(posedge i_sys_clk) berr <= 1'b1;
    @(posedge i_sys_clk) berr <= 1'b0;
    rd_chk(16'h1006, 16'h0018);
    wr_reg(16'h1006, 16'h0080);
    step(3);
    rd_chk(16'h1006, 16'h0090);
    `CHK("held", 1'b1, mrst)
    rd_chk(16'h100E, 16'h0004);
    wr_reg(16'h1008, 16'h0080);
    step(3);
    `CHK("held", 1'b0, mrst)
  endtask
  task automatic t_status();
    {ev, bsy, cr, prg, term} <= {4'hF, 4'hF};
    step(4);
    rd_chk(16'h100E, 16'h0067);
    {ev, bsy, cr, prg, cb, mt, term} <= 10'h030;
    step(4);
    rd_chk(16'h100E, 16'h008C);
    {cb, mt, full, term} <= 7'h15;
    step(4);
    rd_chk(16'h100E, 16'h0004);
    full <= 1'b0;
  endtask
  task automatic t_irq();
    wr_reg(16'h100A, 16'hFFFB);
    rd_chk(16'h100A, 16'h0003);
    `CHK("level", 3'h3, lvl)
    {trg, cnt} <= {5'h02, 5'h02};
    step(3);
    `CHK("irq", 1'b1, irq)
    rd_chk(16'h100E, 16'h0100);
    trg <= 5'h00;
    step(3);
    `CHK("irq", 1'b0, irq)
    wr_reg(16'h100A, 16'h0000);
    trg <= 5'h02;
    step(3);
    `CHK("irq", 1'b0, irq)
    wr_reg(16'h100C, 16'h01A5);
    u_vmcsr_master.xfer(2'd2, 16'h0000, 16'h0000, ok, q);
    `CHK("vector", 16'h00A5, q)
    rd_chk(16'h100C, 16'h00A5);
  endtask
  task automatic t_slot();
    wr_reg(16'h1004, 16'h1234);
    rd_chk(16'h1004, 16'h0034);
    // Frozen clock enable: the write strobe must be ignored
    ce <= 1'b0;
    wr_reg(16'h1004, 16'h0055);
    ce <= 1'b1;
    `CHK("chain", 8'h34, chain)
    wr_reg(16'h1002, 16'h0013);
    `CHK("slot ack", 1'b0, ok)
    `CHK("bare slot", 5'h1F, bare_slot)
    // Master resets after the slot write; held soft reset applies it
    wr_reg(16'h1006, 16'h0080);
    wr_reg(16'h1008, 16'h0080);
    `CHK("bare slot", 5'h13, bare_slot)
    lines <= 5'h13;
    // A changed slot only lands on the next reset; hard reset drops a written slot
    hw_reset();
    `CHK("slot", 5'h13, slot)
    rd_chk(16'h1004, 16'h00AA);
    rd_chk(16'h1006, 16'h0000);
    vld <= 1'b0;
    hw_reset();
    `CHK("slot", 5'h1F, slot)
    rd_chk(16'h100E, 16'h0010);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    step(3000);
    mismatches++;
    print_verdict();
  end
  initial begin
    step(10);
    i_nrst <= 1'b1;
    step(2);
    t_reset();
    t_bits();
    t_status();
    t_irq();
    t_slot();
    print_verdict();
  end
endmodule
